// ==== scpwc_defines.svh ====
// Offsets, field positions, reset values and timing counts of the clock control
`ifndef SCPWC_DEFINES_SVH
`define SCPWC_DEFINES_SVH
// ***************************************************************
// Register byte offsets
// ***************************************************************
`define SCPWC_OFF_OSC 12'h000
`define SCPWC_OFF_SYS 12'h004
`define SCPWC_OFF_PLL 12'h008
`define SCPWC_OFF_CKSEL 12'h00C
// ***************************************************************
// Oscillator control fields
// ***************************************************************
`define SCPWC_OSC_WSTART 0
`define SCPWC_OSC_WACT 1
`define SCPWC_OSC_PLL_POWER_ON 2
`define SCPWC_OSC_FASTEN 8
`define SCPWC_OSC_SLOWEN 9
`define SCPWC_OSC_WSEL 10
`define SCPWC_OSC_WLO 12
`define SCPWC_OSC_WUP 20
// ***************************************************************
// System config, PLL and select fields
// ***************************************************************
`define SCPWC_SYS_GEAR 0
`define SCPWC_SYS_PRCK 8
`define SCPWC_SYS_PSLOW 12
`define SCPWC_PLL_SEL 0
`define SCPWC_PLL_ND 3
`define SCPWC_PLL_SCALE 8
`define SCPWC_PLL_IN 9
`define SCPWC_PLL_RANGE 12
`define SCPWC_PLL_RESET 16'h7116
`define SCPWC_CK_FLAG 0
`define SCPWC_CK_SEL 1
// ***************************************************************
// Timing
// ***************************************************************
`define SCPWC_SWITCH_CYCLES 4'h4
`define SCPWC_PLL_X8_RANGE 4'hA
`endif

// ==== scpwc_pkg.sv ====
// Types of the clock control block
package scpwc_pkg;
   typedef enum logic [1:0] {
      SCPWC_SW_IDLE = 2'b00,
      SCPWC_SW_WAIT = 2'b01
   } scpwc_sw_t;
endpackage

// ==== scpwc_divider.sv ====
// Power-of-two clock-enable divider for gear and prescaler clocks
`include "scpwc_defines.svh"
module scpwc_divider (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic [2:0] divSel,
   output logic tick
);
   import scpwc_pkg::*;
   typedef struct packed {
      logic [4:0] cnt;
      logic tick;
   } scpwc_div_t;
   scpwc_div_t state_q;
   scpwc_div_t state_d;
   logic [4:0] limit;
   // ***************************************************************
   // Divide by 2**divSel; codes above five clamp to 32
   // ***************************************************************
   always_comb begin
      limit = 5'h1F;
      if (divSel < 3'h5) begin
         limit = 5'((6'h01 << divSel) - 6'h01);
      end
      state_d = state_q;
      state_d.tick = (state_q.cnt >= limit);
      state_d.cnt = (state_q.cnt >= limit) ? 5'h00 : 5'(state_q.cnt + 5'h01);
   end
   // Register update
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_q <= '0;
      end else if (ce) begin
         state_q <= state_d;
      end
   end
   assign tick = state_q.tick;
endmodule

// ==== scpwc_top.sv ====
// Clock selection, PLL control and warm-up timer with APB registers
`include "scpwc_defines.svh"
//
// Function
// - System clock: gear when select 0, slow 1
// - Delayed switch, status flag shows clock used
// - Gear clock is high-speed divided 1,2,4,8
// - Prescaler: slow clock or periph divided 1..32
// - Reset: oscillators on, PLL off, no division
// - PLL stays off until software enables
// - Warm-up start bit begins count, chosen clock
// - Warm-up flag high while counting, then low
// - Fast warm-up: 16-bit counter, upper 12 compared
// - Slow warm-up: 18-bit counter, 14 bits compared
// - PLL gives 4x or 8x, selected as high-speed
module scpwc_top (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fastOscTick,
   input wire logic slowOscTick,
   input wire logic slowOscRunning,
   input wire logic gearRunning,
   output logic fastOscEnable,
   output logic slowOscEnable,
   output logic pllPowerOn,
   output logic pllTimesEight,
   output logic pllOutputSelect,
   output logic sysFromSlow,
   output logic gearTick,
   output logic prescalerTick,
   output logic prescalerFromSlow,
   output logic warmupActive
);
   import scpwc_pkg::*;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic fastEn;
      logic slowEn;
      logic pll_power_on;
      logic wSel;
      logic wAct;
      logic [11:0] wUp;
      logic [1:0] wLo;
      logic [17:0] wCnt;
      logic [2:0] gear;
      logic [2:0] prck;
      logic pSlow;
      logic [15:0] pllCfg;
      logic pllX8;
      logic ckSel;
      logic ckFlag;
      scpwc_sw_t sw;
      logic [3:0] swCnt;
      logic gearTick;
      logic preTick;
      logic preSlow;
   } scpwc_state_t;
   scpwc_state_t s_q;
   scpwc_state_t s_d;
   logic gearDivTick;
   logic periphDivTick;
   logic wTick;
   logic wDone;
   logic wrEn;
   logic [2:0] periphSel;
   // ***************************************************************
   // Dividers
   // ***************************************************************
   // Gear divider runs on the high-speed clock enable
   scpwc_divider u_gear (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce & fastOscTick),
      .divSel(s_q.gear),
      .tick(gearDivTick)
   );
   // Prescaler divider counts gear ticks, the peripheral base rate
   scpwc_divider u_pre (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce & gearDivTick & fastOscTick),
      .divSel(periphSel),
      .tick(periphDivTick)
   );
   assign periphSel = s_q.prck;
   // ***************************************************************
   // Warm-up compare
   // ***************************************************************
   assign wTick = s_q.wSel ? slowOscTick : fastOscTick;
   // Low four counter bits never take part in the compare
   always_comb begin
      if (s_q.wSel) begin
         wDone = (s_q.wCnt[17:4] >= {s_q.wUp, s_q.wLo});
      end else begin
         wDone = (s_q.wCnt[15:4] >= s_q.wUp);
      end
   end
   assign wrEn = psel & penable & pwrite;
   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      s_d.pready = psel & ~s_q.pready;
      s_d.pslverr = 1'b0;
      // Warm-up counting; ends when compare reached
      if (s_q.wAct) begin
         if (wDone) begin
            s_d.wAct = 1'b0;
         end else if (wTick) begin
            s_d.wCnt = 18'(s_q.wCnt + 18'h0_0001);
         end
      end
      // Glitch-free switch: wait delay and a running new source
      unique case (s_q.sw)
         SCPWC_SW_IDLE: begin
            if (s_q.ckSel != s_q.ckFlag) begin
               s_d.sw = SCPWC_SW_WAIT;
               s_d.swCnt = `SCPWC_SWITCH_CYCLES;
            end
         end
         SCPWC_SW_WAIT: begin
            if (s_q.ckSel == s_q.ckFlag) begin
               s_d.sw = SCPWC_SW_IDLE;
            end else if (s_q.swCnt != 4'h0) begin
               s_d.swCnt = 4'(s_q.swCnt - 4'h1);
            end else if (s_q.ckSel ? slowOscRunning : gearRunning) begin
               s_d.ckFlag = s_q.ckSel;
               s_d.sw = SCPWC_SW_IDLE;
            end
         end
      endcase
      // Register writes
      if (wrEn & s_q.pready) begin
         unique case (paddr)
            `SCPWC_OFF_OSC: begin
               s_d.fastEn = pwdata[`SCPWC_OSC_FASTEN];
               s_d.slowEn = pwdata[`SCPWC_OSC_SLOWEN];
               s_d.pll_power_on = pwdata[`SCPWC_OSC_PLL_POWER_ON];
               s_d.wSel = pwdata[`SCPWC_OSC_WSEL];
               s_d.wLo = pwdata[`SCPWC_OSC_WLO +: 2];
               s_d.wUp = pwdata[`SCPWC_OSC_WUP +: 12];
               if (pwdata[`SCPWC_OSC_WSTART]) begin
                  s_d.wAct = 1'b1;
                  s_d.wCnt = '0;
               end
            end
            `SCPWC_OFF_SYS: begin
               s_d.gear = {1'b0, pwdata[`SCPWC_SYS_GEAR +: 2]};
               s_d.prck = pwdata[`SCPWC_SYS_PRCK +: 3];
               s_d.pSlow = pwdata[`SCPWC_SYS_PSLOW];
            end
            `SCPWC_OFF_PLL: begin
               // Multiplier fields lock while PLL powered, select stays free
               if (!s_q.pll_power_on) begin
                  s_d.pllCfg = {pwdata[15:1], 1'b0};
               end
               s_d.pllCfg[`SCPWC_PLL_SEL] = pwdata[`SCPWC_PLL_SEL];
            end
            `SCPWC_OFF_CKSEL: begin
               s_d.ckSel = pwdata[`SCPWC_CK_SEL];
            end
            default: begin
               s_d.pslverr = 1'b0;
            end
         endcase
      end
      // Error decided in setup so it stands together with pready
      if (psel & ~s_q.pready) begin
         unique case (paddr)
            `SCPWC_OFF_OSC, `SCPWC_OFF_SYS, `SCPWC_OFF_PLL,
            `SCPWC_OFF_CKSEL: begin
               s_d.pslverr = 1'b0;
            end
            default: begin
               s_d.pslverr = 1'b1;
            end
         endcase
      end
      // Read mux; data held ready for the access phase
      s_d.prdata = 32'h0000_0000;
      unique case (paddr)
         `SCPWC_OFF_OSC: begin
            s_d.prdata[`SCPWC_OSC_WACT] = s_d.wAct;
            s_d.prdata[`SCPWC_OSC_PLL_POWER_ON] = s_d.pll_power_on;
            s_d.prdata[`SCPWC_OSC_FASTEN] = s_d.fastEn;
            s_d.prdata[`SCPWC_OSC_SLOWEN] = s_d.slowEn;
            s_d.prdata[`SCPWC_OSC_WSEL] = s_d.wSel;
            s_d.prdata[`SCPWC_OSC_WLO +: 2] = s_d.wLo;
            s_d.prdata[`SCPWC_OSC_WUP +: 12] = s_d.wUp;
         end
         `SCPWC_OFF_SYS: begin
            s_d.prdata[`SCPWC_SYS_GEAR +: 3] = s_d.gear;
            s_d.prdata[`SCPWC_SYS_PRCK +: 3] = s_d.prck;
            s_d.prdata[`SCPWC_SYS_PSLOW] = s_d.pSlow;
         end
         `SCPWC_OFF_PLL: begin
            s_d.prdata[15:0] = s_d.pllCfg;
         end
         `SCPWC_OFF_CKSEL: begin
            s_d.prdata[`SCPWC_CK_SEL] = s_d.ckSel;
            s_d.prdata[`SCPWC_CK_FLAG] = s_d.ckFlag;
         end
         default: begin
            s_d.prdata = 32'h0000_0000;
         end
      endcase
      // Multiplier decode kept in a flop so the output is glitch-free
      s_d.pllX8 = (s_d.pllCfg[15:12] == `SCPWC_PLL_X8_RANGE);
      // Registered clock enables for gear and prescaler
      s_d.gearTick = gearDivTick & fastOscTick;
      s_d.preSlow = s_q.pSlow;
      if (s_q.pSlow) begin
         s_d.preTick = slowOscTick;
      end else if (s_q.prck == 3'h0) begin
         s_d.preTick = gearDivTick & fastOscTick;
      end else begin
         s_d.preTick = periphDivTick & gearDivTick & fastOscTick;
      end
   end
   // ***************************************************************
   // State register; reset gives oscillators on, PLL off, gear 1/1
   // ***************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.fastEn <= 1'b1;
         s_q.slowEn <= 1'b1;
         s_q.pllCfg <= `SCPWC_PLL_RESET;
         s_q.sw <= SCPWC_SW_IDLE;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
   // ***************************************************************
   // Outputs, all from flip-flops
   // ***************************************************************
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign fastOscEnable = s_q.fastEn;
   assign slowOscEnable = s_q.slowEn;
   assign pllPowerOn = s_q.pll_power_on;
   // Eight times when range code says so
   assign pllTimesEight = s_q.pllX8;
   assign pllOutputSelect = s_q.pllCfg[`SCPWC_PLL_SEL];
   assign sysFromSlow = s_q.ckFlag;
   assign gearTick = s_q.gearTick;
   assign prescalerTick = s_q.preTick;
   assign prescalerFromSlow = s_q.preSlow;
   assign warmupActive = s_q.wAct;
endmodule

// ==== scpwc_sva.sv ====
// Port checker for the clock control block
module scpwc_sva (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic slowOscRunning,
   input wire logic gearRunning,
   input wire logic pllPowerOn,
   input wire logic pllTimesEight,
   input wire logic pllOutputSelect,
   input wire logic sysFromSlow,
   input wire logic prescalerFromSlow,
   input wire logic warmupActive
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Committed writes, the only legal cause of control changes
   logic wr, wrOsc, wrPll;
   assign wr = psel && penable && pready && pwrite;
   assign wrOsc = wr && paddr == 12'h000;
   assign wrPll = wr && paddr == 12'h008;
   // Flag must not jump ahead of the switch delay
   sequence holdGear;
      !sysFromSlow [*3];
   endsequence
   AST_SW_DELAY:
      assert property (wr && paddr == 12'h00C && pwdata[1] && !sysFromSlow
         |=> holdGear) else $error("switch too early");
   AST_RISE_SLOW:
      assert property ($rose(sysFromSlow) |-> slowOscRunning)
         else $error("slow source not running");
   AST_FALL_GEAR:
      assert property ($fell(sysFromSlow) |-> gearRunning)
         else $error("gear source not running");
   AST_PLL_ON:
      assert property ($rose(pllPowerOn) |-> $past(wrOsc && pwdata[2]))
         else $error("pll on without write");
   AST_WARM_START:
      assert property ($rose(warmupActive) |-> $past(wrOsc && pwdata[0]))
         else $error("warm-up without start");
   AST_PRE_SRC:
      assert property ($changed(prescalerFromSlow) |-> $past(wr, 2)
         && $past(paddr, 2) == 12'h004
         && $past(pwdata[12], 2) == prescalerFromSlow)
         else $error("prescaler source moved");
   AST_PLL_SEL:
      assert property ($changed(pllOutputSelect) |-> $past(wrPll)
         && $past(pwdata[0]) == pllOutputSelect) else $error("pll select");
   AST_PLL_X8:
      assert property ($changed(pllTimesEight) |-> $past(wrPll && !pllPowerOn))
         else $error("pll fields changed while on");
endmodule
bind scpwc_top scpwc_sva scpwc_sva_i (.clk_sys, .rst, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .slowOscRunning, .gearRunning,
   .pllPowerOn, .pllTimesEight, .pllOutputSelect, .sysFromSlow,
   .prescalerFromSlow, .warmupActive);

// ==== test_system_clock_pll_warmup_control.sv ====
// Self-checking bench of the clock control block
module test_system_clock_pll_warmup_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, fastOscTick = 1'b0, slowOscTick = 1'b0, slvErr;
   logic slowOscRunning = 1'b0, gearRunning = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = '0, seed = 32'h0000_9adf, rv, rd, prdata;
   logic pready, pslverr, fastOscEnable, slowOscEnable, pllPowerOn;
   logic pllTimesEight, pllOutputSelect, sysFromSlow, gearTick;
   logic prescalerTick, prescalerFromSlow, warmupActive;
   int errTotal = 0, checksDone = 0, fastTot = 0, slowTot = 0;
   int gearTot = 0, preTot = 0;
   scpwc_top scpwc_top_i (.clk_sys, .rst, .ce, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .fastOscTick,
      .slowOscTick, .slowOscRunning, .gearRunning, .fastOscEnable,
      .slowOscEnable, .pllPowerOn, .pllTimesEight, .pllOutputSelect,
      .sysFromSlow, .gearTick, .prescalerTick, .prescalerFromSlow,
      .warmupActive);
   // 125 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic near(input int a, input int b, input int t);
      return (a - b <= t) && (b - a <= t);
   endfunction
   // Random oscillator edges; running totals give the expected ratios
   always @(posedge clk_sys) begin
      fastTot += int'(fastOscTick === 1'b1);
      slowTot += int'(slowOscTick === 1'b1);
      gearTot += int'(gearTick === 1'b1);
      preTot += int'(prescalerTick === 1'b1);
      seed = xs(seed);
      rv <= seed;
      fastOscTick <= seed[3];
      slowOscTick <= seed[9];
   end
   task automatic giveVerdict;
      $display("checks %0d mismatches %0d", checksDone, errTotal);
      if (errTotal == 0 && checksDone > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] x,
      input string m);
      checksDone++;
      if (g !== x) begin
         errTotal++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, g, x);
      end
   endtask
   // Hung waits end the run through the verdict
   task automatic hung;
      errTotal++;
      $display("MISMATCH %0t wait ran out", $time);
      giveVerdict();
   endtask
   // One APB transfer; request held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 40);
      rd = prdata;
      slvErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 40) hung();
      @(negedge clk_sys);
   endtask
   task automatic waitSig(input logic w, input logic v, input int lim);
      int n;
      n = 0;
      while ((w ? sysFromSlow : warmupActive) !== v && n < lim) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= lim) hung();
   endtask
   // Program, read back, start and time one warm-up
   task automatic warm(input logic [31:0] v, input int e, input logic s);
      int t;
      apb(1'b1, 12'h000, v);
      apb(1'b0, 12'h000, '0);
      chk(rd, v, "count rb");
      t = s ? slowTot : fastTot;
      apb(1'b1, 12'h000, v | 32'h0000_0001);
      chk(warmupActive, 1'b1, "warm busy");
      waitSig(1'b0, 1'b0, 4000);
      t = (s ? slowTot : fastTot) - t;
      chk(near(t, e, 8), 1'b1, "warm len");
   endtask
   initial begin
      int u;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      chk({fastOscEnable, slowOscEnable, pllPowerOn}, 3'h6, "rst osc");
      chk({sysFromSlow, prescalerFromSlow, warmupActive}, '0, "rst");
      apb(1'b0, 12'h008, '0);
      chk(rd, 32'h0000_7116, "pll rst");
      apb(1'b1, 12'h00C, 32'hFFFF_FFFD);
      apb(1'b0, 12'h00C, '0);
      chk(rd, '0, "cksel ro");
      apb(1'b0, 12'h010, '0);
      chk({slvErr, rd[0]}, 2'h2, "unmapped");
      $display("reset test done");
      // Each gear setting, and prescaler codes 0, 4 and 5 at gear 1/1, against random edges
      for (int i = 0; i < 6; i++) begin
         int g, f, q, p;
         g = (i < 4) ? i : 0;
         apb(1'b1, 12'h004, (i << 8) | g);
         apb(1'b0, 12'h004, '0);
         chk(rd, (i << 8) | g, "sys rb");
         f = fastTot;
         q = gearTot;
         p = preTot;
         repeat (256) @(posedge clk_sys);
         q = (gearTot - q) << g;
         p = (preTot - p) << i;
         chk(near(q, fastTot - f, 2 + (1 << g)), 1'b1, "gear");
         if (g == 0) chk(near(p, fastTot - f, 2 + (1 << i)), 1'b1, "pre");
      end
      apb(1'b1, 12'h004, 32'h0000_1000);
      @(negedge clk_sys);
      chk(prescalerFromSlow, 1'b1, "pre slow");
      $display("divider test done");
      u = 1 + rv[1:0];
      warm({u[11:0], 20'h0_0300}, 16 * u, 1'b0);
      warm(32'h0010_2700, 96, 1'b1);
      $display("warm-up test done");
      // Switch must wait for the slow source to run
      apb(1'b1, 12'h00C, 32'h0000_0002);
      repeat (12) @(posedge clk_sys);
      chk(sysFromSlow, 1'b0, "early switch");
      slowOscRunning <= 1'b1;
      waitSig(1'b1, 1'b1, 12);
      apb(1'b0, 12'h00C, '0);
      chk(rd, 32'h0000_0003, "cksel slow");
      apb(1'b1, 12'h00C, '0);
      waitSig(1'b1, 1'b0, 12);
      $display("switch test done");
      // Fields locked while the PLL runs, free once it stops
      apb(1'b1, 12'h008, 32'h0000_A33E);
      chk(pllTimesEight, 1'b1, "x8");
      apb(1'b1, 12'h000, 32'h0000_0304);
      chk(pllPowerOn, 1'b1, "pll on");
      apb(1'b1, 12'h008, 32'h0000_701F);
      apb(1'b0, 12'h008, '0);
      chk(rd, 32'h0000_A33F, "locked");
      chk(pllOutputSelect, 1'b1, "pll sel");
      apb(1'b1, 12'h008, 32'h0000_A33E);
      apb(1'b1, 12'h000, 32'h0000_0300);
      apb(1'b1, 12'h008, 32'h0000_701E);
      chk({pllTimesEight, pllOutputSelect}, '0, "x4");
      $display("pll test done");
      giveVerdict();
   end
endmodule
